/* File: gwe_pkg.sv */
// Types shared by the wake gating block.
package gwe_pkg;
  typedef logic [7:0] gwe_byte_t;
  typedef enum logic [1:0] {
    GWE_GRP_G1  = 2'b00,
    GWE_GRP_G2  = 2'b01,
    GWE_GRP_MIX = 2'b10,
    GWE_GRP_G5  = 2'b11
  } gwe_grp_e;
endpackage

/* File: gwe_regs.svh */
// Register offsets, field positions, reset values and widths of the wake gating block.
`ifndef GWE_REGS_SVH
`define GWE_REGS_SVH
`define GWE_ADDR_W          8
`define GWE_DATA_W          8
`define GWE_OFF_EN_G1       8'h0b
`define GWE_OFF_EN_G2       8'h0c
`define GWE_OFF_EN_MIX      8'h0d
`define GWE_OFF_EN_G5       8'h0e
`define GWE_OFF_STS_G1      8'h1b
`define GWE_OFF_STS_G2      8'h1c
`define GWE_OFF_STS_MIX     8'h1d
`define GWE_OFF_STS_G5      8'h1e
`define GWE_OFF_CTRL        8'h20
`define GWE_OFF_IRQ_STS     8'h21
`define GWE_OFF_IRQ_MASK    8'h22
`define GWE_OFF_STATE       8'h23
`define GWE_EN_RESET        8'h00
`define GWE_STS_RESET       8'h00
`define GWE_CTRL_MASTER_BIT 0
`define GWE_IRQ_REQ_BIT     0
`define GWE_IRQ_EVT_BIT     1
`define GWE_IRQ_W           2
`endif

/* File: gwe_wake_gate.sv */
// Wake enable gating for general purpose pins with wake status and a wake request output.
//
// Function
// - Request only when enable, status and master set.
// - Disabled source still records status, no request.
// - Register 0x0b bits 0-7 map group one pins.
// - Register 0x0c bits 0-7 map group two pins.
// - Register 0x0d: g3 pins 0-3, g4 0,1, g6 0,1.
// - Register 0x0e bits 0-7 map group five pins.
// - Enable registers read/write, 0x00 on standby reset.
// - Enables survive main, soft and hard resets.
// - Status cleared by writing one; zero ignored.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "gwe_regs.svh"
module gwe_wake_gate (
  // Clock and resets.
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       main_reset_i,
  // Register port.
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Wake sources, one level per pin, high while the pin signals wake.
  input  wire logic [7:0] gpio_g1_i,
  input  wire logic [7:0] gpio_g2_i,
  input  wire logic [3:0] gpio_g3_i,
  input  wire logic [1:0] gpio_g4_i,
  input  wire logic [1:0] gpio_g6_i,
  input  wire logic [7:0] gpio_g5_i,
  // Wake bus and interrupt.
  output logic            wake_request_n_o,
  output logic            irq_o
);

  gwe_pkg::gwe_byte_t en [4];
  gwe_pkg::gwe_byte_t sts [4];
  gwe_pkg::gwe_byte_t src [4];
  logic                        wake_master_enable;
  logic [`GWE_IRQ_W-1:0]       irq_sts;
  logic [`GWE_IRQ_W-1:0]       irq_mask;
  logic [`GWE_IRQ_W-1:0]       irq_evt;
  logic                        next_req;
  logic                        req_q;
  logic                        any_new_sts;
  logic [2:0]                  en_sel;
  logic [2:0]                  sts_sel;

  // Offset decoding is used by both the write and the read path.
  function automatic logic [2:0] en_index(input logic [7:0] a);
    case (a)
      `GWE_OFF_EN_G1:  en_index = {1'b1, gwe_pkg::GWE_GRP_G1};
      `GWE_OFF_EN_G2:  en_index = {1'b1, gwe_pkg::GWE_GRP_G2};
      `GWE_OFF_EN_MIX: en_index = {1'b1, gwe_pkg::GWE_GRP_MIX};
      `GWE_OFF_EN_G5:  en_index = {1'b1, gwe_pkg::GWE_GRP_G5};
      default:         en_index = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] sts_index(input logic [7:0] a);
    case (a)
      `GWE_OFF_STS_G1:  sts_index = {1'b1, gwe_pkg::GWE_GRP_G1};
      `GWE_OFF_STS_G2:  sts_index = {1'b1, gwe_pkg::GWE_GRP_G2};
      `GWE_OFF_STS_MIX: sts_index = {1'b1, gwe_pkg::GWE_GRP_MIX};
      `GWE_OFF_STS_G5:  sts_index = {1'b1, gwe_pkg::GWE_GRP_G5};
      default:          sts_index = 3'h0;
    endcase
  endfunction

  // Decoded once, since a function result cannot be part-selected in place.
  always_comb begin
    en_sel  = en_index(addr_i);
    sts_sel = sts_index(addr_i);
  end

  // Pin to bit mapping of each wake group.
  always_comb begin
    src[0] = gpio_g1_i;
    src[1] = gpio_g2_i;
    src[2] = {gpio_g6_i, gpio_g4_i, gpio_g3_i};
    src[3] = gpio_g5_i;
  end

  // Enables and master enable take only the standby reset, so main resets leave them.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 4; i++) begin
        en[i] <= `GWE_EN_RESET;
      end
    end else if (wr_i && en_sel[2]) begin
      en[en_sel[1:0]] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wake_master_enable <= 1'b0;
    end else if (wr_i && addr_i == `GWE_OFF_CTRL) begin
      wake_master_enable <= wdata_i[`GWE_CTRL_MASTER_BIT];
    end
  end

  // Status records every source regardless of enables; a new event beats a clear.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 4; i++) begin
        sts[i] <= `GWE_STS_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_i && sts_sel[2] && sts_sel[1:0] == 2'(i)) begin
          sts[i] <= (sts[i] & ~wdata_i) | src[i];
        end else begin
          sts[i] <= sts[i] | src[i];
        end
      end
    end
  end

  always_comb begin
    next_req = 1'b0;
    any_new_sts = 1'b0;
    for (int i = 0; i < 4; i++) begin
      next_req = next_req | (|(sts[i] & en[i]));
      any_new_sts = any_new_sts | (|(src[i] & ~sts[i]));
    end
    next_req = next_req & wake_master_enable;
  end

  // Main reset drops the pin and req_q, never the enable state behind it.
  always_ff @(posedge mclk_i) begin
    if (reset_i || main_reset_i) begin
      req_q <= 1'b0;
      wake_request_n_o <= 1'b1;
    end else begin
      req_q <= next_req;
      wake_request_n_o <= ~next_req;
    end
  end

  // Interrupt events: request rising and any new status bit.
  always_comb begin
    irq_evt = '0;
    irq_evt[`GWE_IRQ_REQ_BIT] = next_req & ~req_q;
    irq_evt[`GWE_IRQ_EVT_BIT] = any_new_sts;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_sts <= '0;
    end else if (rd_i && addr_i == `GWE_OFF_IRQ_STS) begin
      irq_sts <= irq_evt;
    end else begin
      irq_sts <= irq_sts | irq_evt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_mask <= '0;
    end else if (wr_i && addr_i == `GWE_OFF_IRQ_MASK) begin
      irq_mask <= wdata_i[`GWE_IRQ_W-1:0];
    end
  end

  // Uses the next status value so the pin follows the register with no extra lag.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else if (rd_i && addr_i == `GWE_OFF_IRQ_STS) begin
      irq_o <= |(irq_evt & irq_mask);
    end else begin
      irq_o <= |((irq_sts | irq_evt) & irq_mask);
    end
  end

  // Read data stand for exactly one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge mclk_i) begin
    if (reset_i || !rd_i) begin
      rdata_o <= 8'h00;
    end else if (en_sel[2]) begin
      rdata_o <= en[en_sel[1:0]];
    end else if (sts_sel[2]) begin
      rdata_o <= sts[sts_sel[1:0]];
    end else begin
      case (addr_i)
        `GWE_OFF_CTRL:     rdata_o <= {7'h00, wake_master_enable};
        `GWE_OFF_IRQ_STS:  rdata_o <= {6'h00, irq_sts};
        `GWE_OFF_IRQ_MASK: rdata_o <= {6'h00, irq_mask};
        `GWE_OFF_STATE:    rdata_o <= {7'h00, req_q};
        default:           rdata_o <= 8'h00;
      endcase
    end
  end

  a_req_needs_cause: assert property (@(posedge mclk_i) disable iff (reset_i)
    !wake_request_n_o |-> $past(wake_master_enable))
    else $error("wake request without master enable");
  a_req_follows_and: assert property (@(posedge mclk_i) disable iff (reset_i)
    !main_reset_i |=> wake_request_n_o == !$past(next_req))
    else $error("wake request does not follow gated status");
  a_disabled_no_req: assert property (@(posedge mclk_i) disable iff (reset_i)
    (en[0] == 8'h00 && en[1] == 8'h00 && en[2] == 8'h00 && en[3] == 8'h00)
      |=> wake_request_n_o)
    else $error("wake request with all enables off");
  a_sts_records_g1: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g1_i[7] |=> sts[0][7])
    else $error("group one pin seven not recorded");
  a_mix_map_bits: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g6_i[1] && gpio_g4_i[0] |=> sts[2][7] && sts[2][4])
    else $error("mixed register mapping wrong");
  a_en_write_read: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_EN_G5 ##1 rd_i && addr_i == `GWE_OFF_EN_G5
      |=> rdata_o == $past(wdata_i, 2))
    else $error("enable register read back wrong");
  a_main_keeps_en: assert property (@(posedge mclk_i) disable iff (reset_i)
    main_reset_i && !wr_i |=> en[1] == $past(en[1]))
    else $error("enable changed by main reset");
  a_zero_write_keeps: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_STS_G2 && wdata_i == 8'h00
      |=> sts[1] == ($past(sts[1]) | $past(src[1])))
    else $error("status write of zero changed status");
  a_one_clears: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_STS_G1 && wdata_i == 8'hff && gpio_g1_i == 8'h00
      |=> sts[0] == 8'h00)
    else $error("status write of one did not clear");
  a_g2_map: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g2_i[3] |=> sts[1][3])
    else $error("group two mapping wrong");
  a_g5_map: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g5_i[5] |=> sts[3][5])
    else $error("group five mapping wrong");
  a_g1_map: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g1_i[0] |=> sts[0][0])
    else $error("group one mapping wrong");

  // Register port: every enable lands where it was written and reads back unchanged.
  a_rdata_idle_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_en_read_g1: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i == `GWE_OFF_EN_G1 |=> rdata_o == $past(en[0]))
    else $error("group one enable read wrong");
  a_en_read_g2: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i == `GWE_OFF_EN_G2 |=> rdata_o == $past(en[1]))
    else $error("group two enable read wrong");
  a_en_read_mix: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i == `GWE_OFF_EN_MIX |=> rdata_o == $past(en[2]))
    else $error("mixed enable read wrong");
  a_en_read_g5: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i == `GWE_OFF_EN_G5 |=> rdata_o == $past(en[3]))
    else $error("group five enable read wrong");
  a_en_write_g1: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_EN_G1 |=> en[0] == $past(wdata_i))
    else $error("group one enable write lost");
  a_en_write_g2: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_EN_G2 |=> en[1] == $past(wdata_i))
    else $error("group two enable write lost");
  a_en_write_mix: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_EN_MIX |=> en[2] == $past(wdata_i))
    else $error("mixed enable write lost");
  a_en_write_g5: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_EN_G5 |=> en[3] == $past(wdata_i))
    else $error("group five enable write lost");
  a_en_hold_idle: assert property (@(posedge mclk_i) disable iff (reset_i)
    !wr_i |=> $stable(en[0]) && $stable(en[1]) && $stable(en[2]) && $stable(en[3]))
    else $error("enable changed without a write");
  a_unmapped_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == 8'h40 |=> $stable(en[0]) && $stable(en[3]))
    else $error("unmapped write reached an enable");
  a_master_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_CTRL |=> wake_master_enable == $past(wdata_i[0]))
    else $error("master enable write lost");

  // Wake pin, main reset, request state read and interrupt mask.
  a_main_reset_pin: assert property (@(posedge mclk_i) disable iff (reset_i)
    main_reset_i |=> wake_request_n_o)
    else $error("wake request during main reset");
  a_master_off_idle: assert property (@(posedge mclk_i) disable iff (reset_i)
    !wake_master_enable |=> wake_request_n_o)
    else $error("wake request with master enable off");
  a_state_read: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i == `GWE_OFF_STATE |=> rdata_o == {7'h00, $past(req_q)})
    else $error("request state read wrong");
  a_irq_masked: assert property (@(posedge mclk_i) disable iff (reset_i)
    irq_mask == 2'b00 |=> !irq_o)
    else $error("interrupt with every source masked");

  // Status recording and clearing for the remaining pins, and status read back of all four registers.
  a_g3_map: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g3_i[3] |=> sts[2][3])
    else $error("group three mapping wrong");
  a_g4_map: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g4_i[1] |=> sts[2][5])
    else $error("group four mapping wrong");
  a_g6_map: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g6_i[0] |=> sts[2][6])
    else $error("group six mapping wrong");
  a_g2_map0: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g2_i[0] |=> sts[1][0])
    else $error("group two pin zero mapping wrong");
  a_g5_map7: assert property (@(posedge mclk_i) disable iff (reset_i)
    gpio_g5_i[7] |=> sts[3][7])
    else $error("group five pin seven mapping wrong");
  a_g1_sticky: assert property (@(posedge mclk_i) disable iff (reset_i)
    sts[0][1] && !(wr_i && addr_i == `GWE_OFF_STS_G1 && wdata_i[1]) |=> sts[0][1])
    else $error("status bit dropped without a clear");
  a_mix_clears: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_STS_MIX && wdata_i == 8'hff && src[2] == 8'h00
      |=> sts[2] == 8'h00)
    else $error("mixed status not cleared");
  a_g5_clears: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && addr_i == `GWE_OFF_STS_G5 && wdata_i == 8'hff && src[3] == 8'h00
      |=> sts[3] == 8'h00)
    else $error("group five status not cleared");
  a_sts_read_g1: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i == `GWE_OFF_STS_G1 |=> rdata_o == $past(sts[0]))
    else $error("group one status read wrong");
  a_sts_read_g2: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i == `GWE_OFF_STS_G2 |=> rdata_o == $past(sts[1]))
    else $error("group two status read wrong");
  a_sts_read_mix: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i == `GWE_OFF_STS_MIX |=> rdata_o == $past(sts[2]))
    else $error("mixed status read wrong");
  a_sts_read_g5: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i == `GWE_OFF_STS_G5 |=> rdata_o == $past(sts[3]))
    else $error("group five status read wrong");

  c_wake_asserted: cover property (@(posedge mclk_i) disable iff (reset_i)
    wake_request_n_o ##1 !wake_request_n_o);
  c_status_cleared: cover property (@(posedge mclk_i) disable iff (reset_i)
    sts[0] != 8'h00 ##1 sts[0] == 8'h00);
  c_irq_raised: cover property (@(posedge mclk_i) disable iff (reset_i) !irq_o ##1 irq_o);
  c_main_reset_kept: cover property (@(posedge mclk_i) disable iff (reset_i)
    main_reset_i && en[0] != 8'h00);
  c_write_then_read: cover property (@(posedge mclk_i) disable iff (reset_i)
    wr_i && en_sel[2] ##1 rd_i && en_sel[2]);

endmodule

/* File: gwe_wake_sink.sv */
// Model of the system wake logic that counts requests seen on the wake bus.
`timescale 1ns/10ps
module gwe_wake_sink (
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  // Wake bus.
  input  wire logic       wake_request_n_i,
  output logic      [7:0] wake_count_o
);
  logic prev_n;
  // The bus is active low, so each fall from the idle high level is one request.
  always_ff @(posedge mclk_i) begin
    prev_n <= reset_i ? 1'b1 : wake_request_n_i;
    if (reset_i) begin
      wake_count_o <= 8'h00;
    end else if (prev_n && !wake_request_n_i) begin
      wake_count_o <= wake_count_o + 8'h01;
    end
  end
endmodule

/* File: tb.sv */
// Self-checking testbench of the wake gating block.
`timescale 1ns/10ps
`include "gwe_regs.svh"
module tb;
  logic        mclk_i, reset_i, main_reset_i, wr_i, rd_i, wake_n, irq;
  logic [7:0]  addr_i, wdata_i, rdata_o, cnt, v;
  logic [31:0] src;
  int          num_errors = 0, checked = 0, i;
  gwe_wake_gate dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .main_reset_i(main_reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .gpio_g1_i(src[7:0]), .gpio_g2_i(src[15:8]), .gpio_g3_i(src[19:16]),
    .gpio_g4_i(src[21:20]), .gpio_g6_i(src[23:22]), .gpio_g5_i(src[31:24]),
    .wake_request_n_o(wake_n), .irq_o(irq));
  gwe_wake_sink sink_u (.mclk_i(mclk_i), .reset_i(reset_i), .wake_request_n_i(wake_n),
    .wake_count_o(cnt));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // Source k sits at bit k%8 of enable register k/8; status uses the same layout.
  function automatic logic [7:0] bm(int k);
    return 8'h01 << (k % 8);
  endfunction
  function automatic logic [7:0] en(int k);
    return `GWE_OFF_EN_G1 + 8'(k / 8);
  endfunction
  function automatic logic [7:0] st(int k);
    return `GWE_OFF_STS_G1 + 8'(k / 8);
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask
  task automatic summarize();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #500000;
    num_errors++;
    summarize();
  end
  initial begin
    reset_i = 1'b1;
    main_reset_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    src = 32'h0;
    v = 8'($urandom(32'h02ca));
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (i = 0; i < 4; i++) rd(en(8 * i), 8'h00);
    rd(8'h40, 8'h00);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(en(8 * i), v);
      rd(en(8 * i), v);
    end
    $display("readback done");
    wr(`GWE_OFF_CTRL, 8'h01);
    for (i = 0; i < 32; i++) begin
      wr(en(i), ~bm(i));
      src <= 32'h1 << i;
      wt(4);
      chk(wake_n, 1'b1);
      rd(st(i), bm(i));
      wr(st(i), 8'h00);
      rd(st(i), bm(i));
      wr(en(i), bm(i));
      wt(2);
      chk(wake_n, 1'b0);
      wr(`GWE_OFF_CTRL, 8'h00);
      wt(2);
      chk(wake_n, 1'b1);
      src <= 32'h0;
      wr(st(i), bm(i));
      rd(st(i), 8'h00);
      wr(`GWE_OFF_CTRL, 8'h01);
      wr(en(i), 8'h00);
      wt(2);
      chk(wake_n, 1'b1);
    end
    chk(cnt, 8'h20);
    $display("source mapping done");
    chk(irq, 1'b0);
    rd(`GWE_OFF_IRQ_STS, 8'h03);
    wr(`GWE_OFF_IRQ_MASK, 8'h03);
    src <= 32'h8000_0000;
    wr(en(31), 8'h80);
    wt(4);
    chk(irq, 1'b1);
    rd(`GWE_OFF_IRQ_STS, 8'h03);
    wt(1);
    chk(irq, 1'b0);
    $display("interrupt done");
    main_reset_i <= 1'b1;
    wt(3);
    chk(wake_n, 1'b1);
    main_reset_i <= 1'b0;
    wt(3);
    chk(wake_n, 1'b0);
    rd(en(31), 8'h80);
    rd(`GWE_OFF_STATE, 8'h01);
    $display("main reset done");
    src <= 32'h0;
    reset_i <= 1'b1;
    wt(3);
    reset_i <= 1'b0;
    rd(en(31), 8'h00);
    rd(`GWE_OFF_CTRL, 8'h00);
    $display("standby reset done");
    summarize();
  end
endmodule
